// *** logic/irx_pkg.sv ***
`default_nettype none
package irx_pkg;

  // ------------------------------------------------------------
  // Geometry
  // ------------------------------------------------------------
  localparam int unsigned SLOTS = 12;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned RSVD_W = DATA_W - SLOTS;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [15:0] ADDR_STAT_DATA = 16'h0001;
  localparam logic [15:0] ADDR_STAT_LVL0 = 16'h0002;
  localparam logic [15:0] ADDR_STAT_LVL1 = 16'h0003;
  localparam logic [15:0] ADDR_STAT_CEIL1 = 16'h0004;
  localparam logic [15:0] ADDR_STAT_CEIL2 = 16'h0005;
  localparam logic [15:0] ADDR_AUTOCLEAR = 16'h0007;
  localparam logic [15:0] ADDR_EN_Y_DATA = 16'h0015;
  localparam logic [15:0] ADDR_EN_X_LVL0 = 16'h0016;
  localparam logic [15:0] ADDR_EN_X_LVL1 = 16'h0017;
  localparam logic [15:0] ADDR_EN_X_CEIL1 = 16'h0018;
  localparam logic [15:0] ADDR_EN_X_CEIL2 = 16'h0019;

  // ------------------------------------------------------------
  // Reset and read values
  // ------------------------------------------------------------
  localparam logic [11:0] ENABLE_RESET = 12'h000;
  localparam logic [11:0] FLAG_RESET = 12'h000;
  localparam logic [11:0] AUTOCLEAR_RESET = 12'hfff;
  localparam logic [3:0] RESERVED_READ = 4'h0;
  localparam logic [15:0] UNMAPPED_READ = 16'h0000;

endpackage : irx_pkg
`default_nettype wire

// *** logic/irx_slot_flags.sv ***
`timescale 1ns/1ps
`default_nettype none
// Twelve sticky per-slot status flags: set by hardware, cleared by a
// write of one or by an automatic clear. A set in the same cycle as a
// clear wins, so no event is lost.
module irx_slot_flags (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [11:0] set_slots,
  input wire logic [11:0] clr_w1c,
  input wire logic [11:0] clr_auto,
  output logic [11:0] flags
);

  typedef struct packed {
    logic [11:0] flag;
  } irx_flag_state_t;

  irx_flag_state_t s_reg;
  irx_flag_state_t s_next;
  logic [11:0] clr_any;

  assign clr_any = clr_w1c | clr_auto;

  always_comb begin
    s_next = s_reg;
    s_next.flag = (s_reg.flag & ~clr_any) | set_slots;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s_reg.flag <= irx_pkg::FLAG_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign flags = s_reg.flag;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  a_set_over_clear: assert property (
    (set_slots != 12'h000) |=> ((flags & $past(set_slots)) ==
                               $past(set_slots)))
    else $error("flag set lost against a clear");

  a_clear_removes: assert property (
    (clr_any != 12'h000 && set_slots == 12'h000) |=>
      ((flags & $past(clr_any)) == 12'h000))
    else $error("flag not cleared");

endmodule // irx_slot_flags
`default_nettype wire

// *** logic/irx_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module irx_top (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic [11:0] data_update,
  input wire logic [11:0] ch1_over,
  input wire logic [11:0] ch2_over,
  input wire logic [11:0] lvl0_evt,
  input wire logic [11:0] lvl1_evt,
  input wire logic [11:0] slot_data_rd,
  output logic irq_x,
  output logic irq_y
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [11:0] out_y_ready_mask;
    logic [11:0] out_x_lvl0_mask;
    logic [11:0] out_x_lvl1_mask;
    logic [11:0] out_x_ceil1_mask;
    logic [11:0] out_x_ceil2_mask;
    logic [11:0] autoclear;
    logic [15:0] rdata;
    logic irq_x;
    logic irq_y;
  } irx_state_t;

  irx_state_t s_reg;
  irx_state_t s_next;

  logic [11:0] wdata_slots;
  logic [11:0] ready_flag;
  logic [11:0] lvl0_flag;
  logic [11:0] lvl1_flag;
  logic [11:0] ceil1_flag;
  logic [11:0] ceil2_flag;
  logic [11:0] ceil1_set;
  logic [11:0] ceil2_set;
  logic [11:0] ready_autoclr;
  logic [11:0] w1c_ready;
  logic [11:0] w1c_lvl0;
  logic [11:0] w1c_lvl1;
  logic [11:0] w1c_ceil1;
  logic [11:0] w1c_ceil2;
  logic x_pending;
  logic y_pending;

  assign wdata_slots = reg_wdata[11:0];

  // ------------------------------------------------------------
  // Event capture
  // ------------------------------------------------------------
  // Ceiling flags only latch on the data register update strobe so a
  // result that briefly crosses mid-slot does not raise a flag.
  assign ceil1_set = data_update & ch1_over;
  assign ceil2_set = data_update & ch2_over;
  assign ready_autoclr = slot_data_rd & s_reg.autoclear;

  // Write of one clears; write of zero leaves the flag alone.
  assign w1c_ready = (reg_wr && reg_addr == irx_pkg::ADDR_STAT_DATA) ?
                     wdata_slots : 12'h000;
  assign w1c_lvl0 = (reg_wr && reg_addr == irx_pkg::ADDR_STAT_LVL0) ?
                    wdata_slots : 12'h000;
  assign w1c_lvl1 = (reg_wr && reg_addr == irx_pkg::ADDR_STAT_LVL1) ?
                    wdata_slots : 12'h000;
  assign w1c_ceil1 = (reg_wr && reg_addr == irx_pkg::ADDR_STAT_CEIL1) ?
                     wdata_slots : 12'h000;
  assign w1c_ceil2 = (reg_wr && reg_addr == irx_pkg::ADDR_STAT_CEIL2) ?
                     wdata_slots : 12'h000;

  irx_slot_flags u_ready (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .set_slots(data_update),
    .clr_w1c(w1c_ready),
    .clr_auto(ready_autoclr),
    .flags(ready_flag)
  );

  irx_slot_flags u_lvl0 (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .set_slots(lvl0_evt),
    .clr_w1c(w1c_lvl0),
    .clr_auto(12'h000),
    .flags(lvl0_flag)
  );

  irx_slot_flags u_lvl1 (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .set_slots(lvl1_evt),
    .clr_w1c(w1c_lvl1),
    .clr_auto(12'h000),
    .flags(lvl1_flag)
  );

  irx_slot_flags u_ceil1 (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .set_slots(ceil1_set),
    .clr_w1c(w1c_ceil1),
    .clr_auto(12'h000),
    .flags(ceil1_flag)
  );

  irx_slot_flags u_ceil2 (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .set_slots(ceil2_set),
    .clr_w1c(w1c_ceil2),
    .clr_auto(12'h000),
    .flags(ceil2_flag)
  );

  // ------------------------------------------------------------
  // Routing
  // ------------------------------------------------------------
  assign y_pending = |(ready_flag & s_reg.out_y_ready_mask);
  assign x_pending = |((lvl0_flag & s_reg.out_x_lvl0_mask) |
                       (lvl1_flag & s_reg.out_x_lvl1_mask) |
                       (ceil1_flag & s_reg.out_x_ceil1_mask) |
                       (ceil2_flag & s_reg.out_x_ceil2_mask));

  // ------------------------------------------------------------
  // Register port and next state
  // ------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.irq_x = x_pending;
    s_next.irq_y = y_pending;
    if (reg_wr) begin
      case (reg_addr)
        irx_pkg::ADDR_EN_Y_DATA: s_next.out_y_ready_mask = wdata_slots;
        irx_pkg::ADDR_EN_X_LVL0: s_next.out_x_lvl0_mask = wdata_slots;
        irx_pkg::ADDR_EN_X_LVL1: s_next.out_x_lvl1_mask = wdata_slots;
        irx_pkg::ADDR_EN_X_CEIL1: s_next.out_x_ceil1_mask = wdata_slots;
        irx_pkg::ADDR_EN_X_CEIL2: s_next.out_x_ceil2_mask = wdata_slots;
        irx_pkg::ADDR_AUTOCLEAR: s_next.autoclear = wdata_slots;
        default: s_next.autoclear = s_reg.autoclear;
      endcase
    end
    if (reg_rd) begin
      // Upper nibble is reserved and always reads zero
      case (reg_addr)
        irx_pkg::ADDR_STAT_DATA:
          s_next.rdata = {irx_pkg::RESERVED_READ, ready_flag};
        irx_pkg::ADDR_STAT_LVL0:
          s_next.rdata = {irx_pkg::RESERVED_READ, lvl0_flag};
        irx_pkg::ADDR_STAT_LVL1:
          s_next.rdata = {irx_pkg::RESERVED_READ, lvl1_flag};
        irx_pkg::ADDR_STAT_CEIL1:
          s_next.rdata = {irx_pkg::RESERVED_READ, ceil1_flag};
        irx_pkg::ADDR_STAT_CEIL2:
          s_next.rdata = {irx_pkg::RESERVED_READ, ceil2_flag};
        irx_pkg::ADDR_AUTOCLEAR:
          s_next.rdata = {irx_pkg::RESERVED_READ, s_reg.autoclear};
        irx_pkg::ADDR_EN_Y_DATA:
          s_next.rdata = {irx_pkg::RESERVED_READ, s_reg.out_y_ready_mask};
        irx_pkg::ADDR_EN_X_LVL0:
          s_next.rdata = {irx_pkg::RESERVED_READ, s_reg.out_x_lvl0_mask};
        irx_pkg::ADDR_EN_X_LVL1:
          s_next.rdata = {irx_pkg::RESERVED_READ, s_reg.out_x_lvl1_mask};
        irx_pkg::ADDR_EN_X_CEIL1:
          s_next.rdata = {irx_pkg::RESERVED_READ, s_reg.out_x_ceil1_mask};
        irx_pkg::ADDR_EN_X_CEIL2:
          s_next.rdata = {irx_pkg::RESERVED_READ, s_reg.out_x_ceil2_mask};
        default: s_next.rdata = irx_pkg::UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s_reg.out_y_ready_mask <= irx_pkg::ENABLE_RESET;
      s_reg.out_x_lvl0_mask <= irx_pkg::ENABLE_RESET;
      s_reg.out_x_lvl1_mask <= irx_pkg::ENABLE_RESET;
      s_reg.out_x_ceil1_mask <= irx_pkg::ENABLE_RESET;
      s_reg.out_x_ceil2_mask <= irx_pkg::ENABLE_RESET;
      s_reg.autoclear <= irx_pkg::AUTOCLEAR_RESET;
      s_reg.rdata <= irx_pkg::UNMAPPED_READ;
      s_reg.irq_x <= 1'b0;
      s_reg.irq_y <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs are registered, so an interrupt follows its flag by a cycle
  assign irq_x = s_reg.irq_x;
  assign irq_y = s_reg.irq_y;
  assign reg_rdata = s_reg.rdata;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  sequence s_write_x_lvl0;
    reg_wr && reg_addr == irx_pkg::ADDR_EN_X_LVL0;
  endsequence

  sequence s_read_back_x_lvl0;
    reg_rd && reg_addr == irx_pkg::ADDR_EN_X_LVL0 && !reg_wr;
  endsequence

  a_mask_roundtrip: assert property (
    s_write_x_lvl0 ##1 s_read_back_x_lvl0 |=>
      reg_rdata == {irx_pkg::RESERVED_READ, $past(wdata_slots, 2)})
    else $error("level 0 mask read back differs from write");

  a_reserved_zero: assert property (
    $past(reg_rd) |-> reg_rdata[15:12] == irx_pkg::RESERVED_READ)
    else $error("reserved bits read non-zero");

  a_irq_x_or: assert property (
    irq_x == $past(x_pending))
    else $error("output X not the OR of enabled flags");

  a_irq_y_or: assert property (
    irq_y == $past(y_pending))
    else $error("output Y not the OR of enabled data flags");

  a_ceiling_set: assert property (
    (ceil1_set != 12'h000) |=> ((ceil1_flag & $past(ceil1_set)) ==
                               $past(ceil1_set)))
    else $error("ceiling flag not set on update");

  a_autoclear_data: assert property (
    (ready_autoclr != 12'h000 && data_update == 12'h000) |=>
      ((ready_flag & $past(ready_autoclr)) == 12'h000))
    else $error("data-ready flag survived autoclear read");

endmodule // irx_top
`default_nettype wire

// *** test/irx_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Host side of the register port: one strobe per access
module irx_host_model (
  input wire logic ref_clk,
  input wire logic [15:0] reg_rdata,
  output logic [15:0] reg_addr,
  output logic [15:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  initial begin
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // Released lines show the inverse, so stale values never pass
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  // Read data is held until the next read, so a late look is safe
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(posedge ref_clk);
    #1;
    d = reg_rdata;
  endtask
  // Write then read of one address on back-to-back edges
  task automatic wr_rd(input logic [15:0] a, input logic [15:0] d,
                       output logic [15:0] q);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    @(posedge ref_clk);
    #1;
    q = reg_rdata;
  endtask
  task automatic clear_all();
    for (int k = 0; k < 5; k++) begin
      wr(irx_pkg::ADDR_STAT_DATA + 16'(k), 16'h0fff);
    end
  endtask
endmodule  // irx_host_model
`default_nettype wire

// *** test/irx_top_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module irx_top_bench;
  typedef struct packed {
    logic [2:0] kind;
    logic [15:0] mask;
    logic [11:0] slots;
  } irx_row_t;
  logic ref_clk, rstn, reg_wr, reg_rd, irq_x, irq_y;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, rd_val;
  logic [11:0] data_update, ch1_over, ch2_over;
  logic [11:0] lvl0_evt, lvl1_evt, slot_data_rd;
  int num_errors = 0;
  int compares = 0;
  // Kind picks the flag source: 0 data, 1 lvl0, 2 lvl1, 3 ceil1, 4 ceil2
  irx_row_t rows [9] = '{'{3'h0, 16'h0001, 12'h001},
    '{3'h0, 16'h0800, 12'h400}, '{3'h1, 16'hffff, 12'h800},
    '{3'h1, 16'h0020, 12'h010}, '{3'h2, 16'h0800, 12'h800},
    '{3'h3, 16'h0001, 12'h001}, '{3'h3, 16'h0002, 12'h001},
    '{3'h4, 16'h0400, 12'h400}, '{3'h4, 16'hf000, 12'hfff}};
  irx_top i_dut (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .data_update(data_update), .ch1_over(ch1_over),
    .ch2_over(ch2_over), .lvl0_evt(lvl0_evt), .lvl1_evt(lvl1_evt),
    .slot_data_rd(slot_data_rd), .irq_x(irq_x), .irq_y(irq_y));
  irx_host_model i_host (.ref_clk(ref_clk), .reg_rdata(reg_rdata),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd));
  task automatic wrap_up();
    if (num_errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk16({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic pulse(input logic [2:0] k, input logic [11:0] s,
                       input logic [11:0] ov);
    @(posedge ref_clk);
    data_update <= (k == 3'h0 || k >= 3'h3) ? s : 12'h000;
    lvl0_evt <= (k == 3'h1) ? s : 12'h000;
    lvl1_evt <= (k == 3'h2) ? s : 12'h000;
    ch1_over <= (k == 3'h3) ? ov : 12'h000;
    ch2_over <= (k == 3'h4) ? ov : 12'h000;
    @(posedge ref_clk);
    data_update <= 12'h000;
    lvl0_evt <= 12'h000;
    lvl1_evt <= 12'h000;
    ch1_over <= 12'h000;
    ch2_over <= 12'h000;
  endtask
  task automatic strobe_rd(input logic [11:0] s);
    @(posedge ref_clk);
    slot_data_rd <= s;
    @(posedge ref_clk);
    slot_data_rd <= 12'h000;
  endtask
  // Flag lands one edge after its cause, the pin one edge after that
  task automatic settle();
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial begin
    #(25 * 6000);
    num_errors++;
    wrap_up();
  end
  initial begin
    irx_row_t r;
    logic hit;
    logic [15:0] en;
    rstn = 1'b0;
    {data_update, ch1_over, ch2_over} = '0;
    {lvl0_evt, lvl1_evt, slot_data_rd} = '0;
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      r = rows[i];
      hit = |(r.mask[11:0] & r.slots);
      en = irx_pkg::ADDR_EN_Y_DATA + 16'(r.kind);
      i_host.wr(en, r.mask);
      i_host.rd(en, rd_val);
      chk16(rd_val, {4'h0, r.mask[11:0]});
      pulse(r.kind, r.slots, r.slots);
      settle();
      chk1(irq_x, hit && r.kind != 3'h0);
      chk1(irq_y, hit && r.kind == 3'h0);
      i_host.clear_all();
      settle();
      chk1(irq_x, 1'b0);
      chk1(irq_y, 1'b0);
      i_host.wr(en, 16'h0000);
    end
    // Ceiling flag needs the channel over threshold at the update
    i_host.wr(irx_pkg::ADDR_EN_X_CEIL1, 16'h0fff);
    pulse(3'h3, 12'hfff, 12'h000);
    settle();
    chk1(irq_x, 1'b0);
    i_host.clear_all();
    i_host.wr(irx_pkg::ADDR_EN_X_CEIL1, 16'h0000);
    i_host.wr(irx_pkg::ADDR_EN_X_LVL0, 16'h0004);
    pulse(3'h1, 12'h004, 12'h000);
    i_host.wr(irx_pkg::ADDR_STAT_LVL0, 16'h0000);
    settle();
    chk1(irq_x, 1'b1);
    i_host.rd(irx_pkg::ADDR_STAT_LVL0, rd_val);
    chk16(rd_val, 16'h0004);
    i_host.wr(irx_pkg::ADDR_STAT_LVL0, 16'h0004);
    settle();
    chk1(irq_x, 1'b0);
    i_host.wr(irx_pkg::ADDR_EN_Y_DATA, 16'h0008);
    pulse(3'h0, 12'h008, 12'h000);
    strobe_rd(12'h008);
    settle();
    chk1(irq_y, 1'b0);
    i_host.wr(irx_pkg::ADDR_AUTOCLEAR, 16'h0000);
    pulse(3'h0, 12'h008, 12'h000);
    strobe_rd(12'h008);
    settle();
    chk1(irq_y, 1'b1);
    i_host.rd(16'h0030, rd_val);
    chk16(rd_val, 16'h0000);
    i_host.wr_rd(irx_pkg::ADDR_EN_X_LVL0, 16'hfa5c, rd_val);
    chk16(rd_val, 16'h0a5c);
    // Second reset in mid-run must drop every mask, flag and both pins
    for (int k = 0; k < 5; k++) begin
      i_host.wr(irx_pkg::ADDR_EN_Y_DATA + 16'(k), 16'hffff);
    end
    pulse(3'h1, 12'hfff, 12'h000);
    settle();
    chk1(irq_x, 1'b1);
    chk1(irq_y, 1'b1);
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    settle();
    chk1(irq_x, 1'b0);
    chk1(irq_y, 1'b0);
    for (int k = 0; k < 5; k++) begin
      i_host.rd(irx_pkg::ADDR_EN_Y_DATA + 16'(k), rd_val);
      chk16(rd_val, 16'h0000);
      i_host.rd(irx_pkg::ADDR_STAT_DATA + 16'(k), rd_val);
      chk16(rd_val, 16'h0000);
    end
    i_host.rd(irx_pkg::ADDR_AUTOCLEAR, rd_val);
    chk16(rd_val, 16'h0fff);
    wrap_up();
  end
endmodule  // irx_top_bench
`default_nettype wire
